/* ptibd_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ptibd_params.svh"
module ptibd_top
  import ptibd_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         clkEn,
  input  wire ptibd_cfg_t   cfgReq,
  output logic      [31:0]  cfgRdata,
  output logic              cfgHitRegSpace,
  input  wire logic         idLoadStrap,
  input  wire logic         pciDisableStrap,
  input  wire logic         eeLoading,
  input  wire logic         eeImg0Bit,
  input  wire logic         eeImg1Bit,
  input  wire logic         eePrefLoad,
  input  wire logic  [1:0]  eePrefVal,
  input  wire logic         messagingEnable,
  input  wire ptibd_img_t   img0Cfg,
  input  wire ptibd_img_t   img1Cfg,
  input  wire logic         localPrefWr,
  input  wire logic  [1:0]  localPrefVal,
  input  wire logic         addrPhase,
  input  wire logic  [31:0] addrAd,
  input  wire logic         addrIsIo,
  output logic              claimImg0,
  output logic              claimImg1,
  output logic              claimMsg,
  output logic              prefetchImg0,
  output logic              prefetchImg1
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0] base_q [2];
  logic [1:0]  prefetchable_flag_q;
  logic [19:0] msgBase_q;
  logic        inRst_q;
  logic        strapId_q;
  logic        strapDis_q;
  logic [1:0]  imgEn;
  logic [3:0]  bsz   [2];
  logic        spc   [2];
  logic [15:0] wrMask [2];
  logic [15:0] cmpMask [2];
  logic [1:0]  hit;
  logic [7:0]  ofsImg0;
  logic        selImg0;
  logic        selImg1;
  logic        selMsg;
  logic        wrOk;

  assign bsz[0] = img0Cfg.blockSize;
  assign bsz[1] = img1Cfg.blockSize;
  assign spc[0] = img0Cfg.space;
  assign spc[1] = img1Cfg.space;

  // straps caught in the first clocked cycle after reset release
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      inRst_q <= 1'b1;
    else if (clkEn)
      inRst_q <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      strapId_q  <= 1'b0;
      strapDis_q <= 1'b0;
    end
    else if (clkEn && inRst_q)
    begin
      strapId_q  <= idLoadStrap;
      strapDis_q <= pciDisableStrap;
    end
  end

  // ----------------------------------------------------------------------
  // image enables and address layout
  // ----------------------------------------------------------------------
  assign imgEn[0] = (strapId_q & eeImg0Bit) | strapDis_q;
  assign imgEn[1] = (strapId_q & eeImg1Bit) | strapDis_q;
  // image 0 swaps to the first bar when messaging is on
  assign ofsImg0 = messagingEnable ? `PTIBD_OFS_FIRST_BAR
                                   : `PTIBD_OFS_IMG0_HOME;
  assign selImg0 = cfgReq.cfgAddr == ofsImg0;
  assign selImg1 = cfgReq.cfgAddr == `PTIBD_OFS_IMG1;
  // register space moves into the old image 0 slot
  assign selMsg  = messagingEnable &&
                   cfgReq.cfgAddr == `PTIBD_OFS_IMG0_HOME;
  assign wrOk    = cfgReq.cfgWr && !eeLoading;

  // ----------------------------------------------------------------------
  // per-image masks, writes and decode
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_img
      // ones above the block: writable and compared lines
      assign wrMask[gi]  = 16'hffff << bsz[gi];
      assign cmpMask[gi] = wrMask[gi];
      assign hit[gi] = addrPhase && imgEn[gi] && (spc[gi] == addrIsIo) &&
                       ((addrAd[31:16] & cmpMask[gi]) ==
                        (base_q[gi] & cmpMask[gi]));

      // base field, zero on bus reset
      always_ff @(posedge clk_sys)
      begin
        if (!rstn)
          base_q[gi] <= `PTIBD_RST_BASE;
        else if (clkEn && wrOk && imgEn[gi] &&
                 (gi == 0 ? (selImg0 && !messagingEnable) : selImg1))
          base_q[gi] <= cfgReq.cfgWdata[31:16] & wrMask[gi];
      end

      // prefetchable flag: eeprom or local bus, never pci
      always_ff @(posedge clk_sys)
      begin
        if (!rstn)
          prefetchable_flag_q[gi] <= 1'b0;
        else if (clkEn && eePrefLoad)
          prefetchable_flag_q[gi] <= eePrefVal[gi];
        else if (clkEn && localPrefWr && !eeLoading)
          prefetchable_flag_q[gi] <= localPrefVal[gi];
      end
    end
  endgenerate

  // messaging base: no reset at all
  always_ff @(posedge clk_sys)
  begin
    if (clkEn && wrOk && messagingEnable && selImg0)
      msgBase_q <= cfgReq.cfgWdata[31:12];
  end

  // ----------------------------------------------------------------------
  // read mux, registered data
  // ----------------------------------------------------------------------
  logic [31:0] rdImg [2];
  logic [31:0] rdNext;
  assign rdImg[0] = imgEn[0] ? {base_q[0], 12'h000, prefetchable_flag_q[0], 2'b00,
                               spc[0]} : 32'h0000_0000;
  assign rdImg[1] = imgEn[1] ? {base_q[1], 12'h000, prefetchable_flag_q[1], 2'b00,
                               spc[1]} : 32'h0000_0000;
  // messaging bar (first bar) shows base, space bit reads 0
  assign rdNext = (messagingEnable && selImg0) ? {msgBase_q, 12'h000} :
                  selImg0 ? rdImg[0] :
                  selImg1 ? rdImg[1] : 32'h0000_0000;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      cfgRdata <= 32'h0000_0000;
    else if (clkEn && cfgReq.cfgRd)
      cfgRdata <= rdNext;
  end

  // ----------------------------------------------------------------------
  // claims
  // ----------------------------------------------------------------------
  logic        msgHit;
  logic [19:0] msgOfs;
  // page offset into the messaging window
  assign msgOfs = addrAd[31:12] - msgBase_q;
  // above the reserved lowest 4K only
  assign msgHit = addrPhase && messagingEnable && !addrIsIo &&
                  msgOfs >= `PTIBD_MSG_RSVD_TOP &&
                  msgOfs < 20'h00010;
  assign claimImg0 = hit[0] & ~messagingEnable;
  assign claimImg1 = hit[1];
  assign claimMsg  = msgHit | (hit[0] & messagingEnable);
  assign cfgHitRegSpace = selMsg | (!messagingEnable &&
                          cfgReq.cfgAddr == `PTIBD_OFS_FIRST_BAR);
  // flag alone never starts local prefetch
  assign prefetchImg0 = img0Cfg.prefEn;
  assign prefetchImg1 = img1Cfg.prefEn;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_img0_dis_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    !imgEn[0] |-> base_q[0] == 16'h0000 || $past(imgEn[0]))
    else $error("image 0 base nonzero while disabled");
  a_block_wr_mask: assert property (@(posedge clk_sys) disable iff (!rstn)
    clkEn && wrOk && imgEn[0] && selImg0 && !messagingEnable |=>
    (base_q[0] & ~$past(wrMask[0])) == 16'h0000)
    else $error("image 0 base bit below block set");
  a_eeload_block: assert property (@(posedge clk_sys) disable iff (!rstn)
    eeLoading && clkEn |=> $stable(base_q[1]))
    else $error("base changed during eeprom load");
  a_claim_space: assert property (@(posedge clk_sys) disable iff (!rstn)
    claimImg1 |-> imgEn[1] && spc[1] == addrIsIo)
    else $error("image 1 claim with wrong space or disabled");
  a_claim_match: assert property (@(posedge clk_sys) disable iff (!rstn)
    claimImg1 |-> addrAd[31] == base_q[1][15])
    else $error("image 1 claim with top line mismatch");
  a_swap_layout: assert property (@(posedge clk_sys) disable iff (!rstn)
    cfgHitRegSpace && messagingEnable |->
    cfgReq.cfgAddr == `PTIBD_OFS_IMG0_HOME)
    else $error("register space not moved");
  a_prefetchable_flag_enable: assert property (@(posedge clk_sys) disable iff (!rstn)
    prefetchImg0 |-> img0Cfg.prefEn)
    else $error("prefetch without enable");
  a_img_reset: assert property (@(posedge clk_sys)
    !rstn |=> base_q[0] == 16'h0000 && base_q[1] == 16'h0000)
    else $error("image base not cleared by reset");

  // ----------------------------------------------------------------------
  // access and decode checks
  // ----------------------------------------------------------------------
  // image 1 write path, in its two steps
  sequence s_img1_wr;
    clkEn && wrOk && imgEn[1] && selImg1;
  endsequence
  sequence s_img1_masked;
    (base_q[1] & ~$past(wrMask[1])) == 16'h0000;
  endsequence
  a_img1_wr_mask: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_img1_wr |=> s_img1_masked)
    else $error("image 1 base bit below block set");
  // disabled image 1 ignores writes
  a_img1_dis_hold: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clkEn && cfgReq.cfgWr && !imgEn[1] |=> $stable(base_q[1]))
    else $error("disabled image 1 base changed");
  // disabled image 1 reads zero
  a_img1_dis_read: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clkEn && cfgReq.cfgRd && selImg1 && !imgEn[1] |=> cfgRdata == 32'h0000_0000)
    else $error("disabled image 1 read nonzero");
  // disabled image 0 reads zero in the home layout
  a_img0_dis_read: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clkEn && cfgReq.cfgRd && selImg0 && !imgEn[0] && !messagingEnable |=>
    cfgRdata == 32'h0000_0000)
    else $error("disabled image 0 read nonzero");
  // space bit reads what the image setup says
  a_space_ro: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clkEn && cfgReq.cfgRd && selImg1 && imgEn[1] |=>
    cfgRdata[0] == $past(spc[1]))
    else $error("image 1 space bit wrong");
  // messaging bar low bits read zero, memory space
  a_msg_space: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clkEn && cfgReq.cfgRd && messagingEnable && selImg0 |=>
    cfgRdata[11:0] == 12'h000)
    else $error("messaging bar low bits nonzero");
  // reserved first page never claimed
  a_msg_low_page: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    msgHit |-> addrAd[31:12] != msgBase_q)
    else $error("reserved messaging page claimed");
  // image 0 claim gated by enable, space and phase
  a_claim0_gate: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    claimImg0 |-> addrPhase && imgEn[0] && spc[0] == addrIsIo)
    else $error("image 0 claim without enable or space");
  // prefetchable flags move only on eeprom or local writes
  a_prefetchable_flag_no_pci: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clkEn && !eePrefLoad && !localPrefWr |=> $stable(prefetchable_flag_q))
    else $error("prefetchable flag changed from pci");
  // straps hold once caught
  a_strap_hold: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clkEn && !inRst_q |=> $stable(strapDis_q) && $stable(strapId_q))
    else $error("strap latch changed after capture");
  // home layout when messaging is off
  a_layout_home: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !messagingEnable |-> ofsImg0 == `PTIBD_OFS_IMG0_HOME && !selMsg)
    else $error("layout moved with messaging off");
endmodule
`default_nettype wire

/* ptibd_params.svh */
`ifndef PTIBD_PARAMS_SVH
`define PTIBD_PARAMS_SVH
// ----------------------------------------------------------------------
// register offsets in configuration space
// ----------------------------------------------------------------------
`define PTIBD_OFS_FIRST_BAR   8'h10
`define PTIBD_OFS_IMG0_HOME   8'h18
`define PTIBD_OFS_IMG1        8'h1c
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PTIBD_BIT_SPACE       0
`define PTIBD_BIT_PREFETCHABLE_FLAG        3
`define PTIBD_MSG_LO          12
`define PTIBD_IMG_LO          16
// eeprom enable bits: byte 7 bit 5, byte 8 bit 7
`define PTIBD_EE_IMG0_BYTE    7
`define PTIBD_EE_IMG0_BIT     5
`define PTIBD_EE_IMG1_BYTE    8
`define PTIBD_EE_IMG1_BIT     7
// ----------------------------------------------------------------------
// reset values and reserved messaging pages
// ----------------------------------------------------------------------
`define PTIBD_RST_BASE        16'h0000
`define PTIBD_RST_MSG         20'h00000
`define PTIBD_MSG_RSVD_TOP    20'h00001
`endif

/* ptibd_pkg.sv */
package ptibd_pkg;
  // host-side configuration access
  typedef struct packed {
    logic        cfgWr;
    logic        cfgRd;
    logic [7:0]  cfgAddr;
    logic [31:0] cfgWdata;
  } ptibd_cfg_t;
  // local-bus side image setup
  typedef struct packed {
    logic       prefetchable_flag;
    logic       space;
    logic [3:0] blockSize;
    logic       prefEn;
  } ptibd_img_t;
  typedef enum logic [1:0] {PTIBD_NONE, PTIBD_HIT0, PTIBD_HIT1, PTIBD_HITM}
    ptibd_claim_t;
endpackage

/* ptibd_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ptibd_host
  import ptibd_pkg::*;
(
  input  wire logic        clk_sys,
  output var  ptibd_cfg_t  cfgReq,
  output var  logic        addrPhase,
  output var  logic [31:0] addrAd,
  output var  logic        addrIsIo
);
  // ----------------------------------------------------------------------
  // pci host model
  // ----------------------------------------------------------------------
  // idle bus shows inverted address and data leftovers, addrIsIo keeps its last value
  initial
  begin
    cfgReq = '0;
    addrPhase = 1'b0;
    addrAd = 32'h0;
    addrIsIo = 1'b0;
  end
  // one configuration cycle, released after the taking edge
  task automatic cfg(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
  begin
    @(posedge clk_sys);
    cfgReq <= '{w, ~w, a, d};
    @(posedge clk_sys);
    cfgReq <= '{1'b0, 1'b0, ~a, ~d};
  end
  endtask
  // one address phase of a memory or io transaction
  task automatic probe(input logic [31:0] a, input logic io);
  begin
    @(posedge clk_sys);
    addrPhase <= 1'b1;
    addrAd <= a;
    addrIsIo <= io;
    @(posedge clk_sys);
    addrPhase <= 1'b0;
    addrAd <= ~a;
  end
  endtask
endmodule
`default_nettype wire

/* pci_target_image_base_decode_test.sv */
`timescale 1ns/1ps
`default_nettype none
module pci_target_image_base_decode_test;
  import ptibd_pkg::*;
  logic        clk_sys, rstn, clkEn, idLoadStrap, pciDisableStrap, rdSeen;
  logic        eeLoading, eeImg0Bit, eeImg1Bit, eePrefLoad, localPrefWr;
  logic        messagingEnable, addrPhase, addrIsIo, cfgHitRegSpace;
  logic        claimImg0, claimImg1, claimMsg, prefetchImg0, prefetchImg1;
  logic [1:0]  eePrefVal, localPrefVal;
  logic [31:0] cfgRdata, addrAd, d, ad;
  logic [15:0] ba;
  ptibd_cfg_t  cfgReq;
  ptibd_img_t  img0Cfg, img1Cfg;
  logic [31:0] rdQ[$];
  logic [1:0]  clQ[$];
  logic        hitQ[$];
  logic        msgOn;
  int          fails, checks, cyc, seed;
  // ----------------------------------------------------------------------
  // design and host
  // ----------------------------------------------------------------------
  ptibd_top DUT (.clk_sys, .rstn, .clkEn, .cfgReq, .cfgRdata,
    .cfgHitRegSpace, .idLoadStrap, .pciDisableStrap, .eeLoading,
    .eeImg0Bit, .eeImg1Bit, .eePrefLoad, .eePrefVal, .messagingEnable,
    .img0Cfg, .img1Cfg, .localPrefWr, .localPrefVal, .addrPhase, .addrAd,
    .addrIsIo, .claimImg0, .claimImg1, .claimMsg, .prefetchImg0,
    .prefetchImg1);
  ptibd_host host (.clk_sys, .cfgReq, .addrPhase, .addrAd, .addrIsIo);
  // clock and cycle ceiling
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      finish_test;
    end
  end
  // compare one result against its oldest note
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
  begin
    rdQ.push_back(e);
    hitQ.push_back(a == (msgOn ? 8'h18 : 8'h10));
    host.cfg(1'b0, a, 32'h0);
  end
  endtask
  task automatic pr(input logic [31:0] a, input logic io, input logic [1:0] e);
  begin
    clQ.push_back(e);
    host.probe(a, io);
  end
  endtask
  task automatic finish_test;
  begin
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // watcher: read data one edge after the read, claims during phases
  always @(posedge clk_sys)
    rdSeen <= cfgReq.cfgRd & rstn;
  always @(negedge clk_sys)
  begin
    if (rdSeen)
      chk(cfgRdata, rdQ.pop_front());
    if (cfgReq.cfgRd)
      chk({31'h0, cfgHitRegSpace}, {31'h0, hitQ.pop_front()});
    if (addrPhase)
      chk({28'h0, claimMsg, claimImg0, claimImg1, prefetchImg0},
          {28'h0, 1'b0, clQ.pop_front(), img0Cfg.prefEn});
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {clk_sys, rstn, pciDisableStrap, eeImg1Bit, eePrefLoad} = '0;
    {messagingEnable, localPrefWr, localPrefVal, eePrefVal} = '0;
    {clkEn, idLoadStrap, eeLoading, eeImg0Bit} = 4'hf;
    {fails, checks, cyc} = '0;
    msgOn = 1'b0;
    seed = 512;
    img0Cfg = '0;
    img1Cfg = '{1'b0, 1'b1, 4'hf, 1'b0};
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    eePrefLoad <= 1'b1;
    eePrefVal <= 2'b01;
    @(posedge clk_sys);
    eePrefLoad <= 1'b0;
    host.cfg(1'b1, 8'h18, 32'hffffffff);
    eeLoading <= 1'b0;
    rd(8'h18, 32'h00000008);
    for (int bs = 0; bs < 16; bs++)
    begin
      img0Cfg.blockSize <= 4'(bs);
      host.cfg(1'b1, 8'h18, 32'hffffffff);
      rd(8'h18, {16'hffff << bs, 16'h0008});
    end
    host.cfg(1'b1, 8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h0);
    @(posedge clk_sys);
    localPrefWr <= 1'b1;
    img0Cfg <= '{1'b0, 1'b0, 4'h4, 1'b1};
    @(posedge clk_sys);
    localPrefWr <= 1'b0;
    d = $random(seed);
    ba = d[31:16] & 16'hfff0;
    host.cfg(1'b1, 8'h18, d);
    rd(8'h18, {ba, 16'h0});
    ad = {ba | 16'h0008, d[15:0]};
    pr(ad, 1'b0, 2'b10);
    pr(ad ^ 32'h00100000, 1'b0, 2'b00);
    pr(ad, 1'b1, 2'b00);
    messagingEnable <= 1'b1;
    msgOn = 1'b1;
    host.cfg(1'b1, 8'h10, 32'hffffffff);
    rd(8'h10, 32'hfffff000);
    rd(8'h18, 32'h0);
    @(posedge clk_sys);
    rstn <= 1'b0;
    pciDisableStrap <= 1'b1;
    idLoadStrap <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h10, 32'hfffff000);
    host.cfg(1'b1, 8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h80000001);
    repeat (3) @(posedge clk_sys);
    finish_test;
  end
endmodule
`default_nettype wire
